// File: rtl/rsf_pkg.sv
/*
 * Shared constants and types of the ramp scaling and input function bank:
 * parameter addresses, reset values, function codes and carrier structs.
 * Assumes a single system clock domain; no other file is required.
 */
`default_nettype none

package rsf_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int          RSF_N_INPUTS      = 4;
   localparam logic [15:0] RSF_ADDR_BOTTOM   = 16'h0660;
   localparam logic [15:0] RSF_ADDR_TOP      = 16'h0662;
   localparam logic [15:0] RSF_ADDR_SEL0     = 16'h0702;
   localparam logic [15:0] RSF_ADDR_SEL_STEP = 16'h0002;
   localparam logic [31:0] RSF_RATIO_RESET   = 32'h0000_0001;
   localparam logic [31:0] RSF_RATIO_MAX     = 32'h7fff_ffff;

   typedef enum logic [15:0] {
      RSF_FN_FREE      = 16'h0001,
      RSF_FN_FAULT_RST = 16'h0002,
      RSF_FN_ENABLE    = 16'h0003,
      RSF_FN_HALT      = 16'h0004,
      RSF_FN_START_POS = 16'h0005,
      RSF_FN_CUR_LIM   = 16'h0006,
      RSF_FN_ZERO_CLMP = 16'h0007,
      RSF_FN_VEL_LIM   = 16'h0008,
      RSF_FN_REF_SW    = 16'h0015,
      RSF_FN_POS_LIM   = 16'h0016,
      RSF_FN_NEG_LIM   = 16'h0017
   } rsf_func_code_t;

   localparam logic [RSF_N_INPUTS-1:0][15:0] RSF_SEL_RESET = {
      RSF_FN_NEG_LIM, RSF_FN_POS_LIM, RSF_FN_REF_SW, RSF_FN_FREE};

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } rsf_req_t;

   typedef struct packed {
      logic free;
      logic fault_reset;
      logic enable;
      logic halt;
      logic start_pos;
      logic cur_lim;
      logic zero_clamp;
      logic vel_lim;
      logic ref_switch;
      logic positive_limit_switch;
      logic negative_limit_switch;
   } rsf_func_t;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic rsf_code_ok(input logic [15:0] code);
      return code inside {[16'h0001:16'h0008], [16'h0015:16'h0017]};
   endfunction

   function automatic rsf_func_t rsf_decode(input logic [15:0] code);
      rsf_func_t f;
      f = '0;
      unique case (code)
         RSF_FN_FREE:      f.free = 1'b1; // RULE8
         RSF_FN_FAULT_RST: f.fault_reset = 1'b1; // RULE8
         RSF_FN_ENABLE:    f.enable = 1'b1; // RULE8
         RSF_FN_HALT:      f.halt = 1'b1; // RULE8
         RSF_FN_START_POS: f.start_pos = 1'b1; // RULE9
         RSF_FN_CUR_LIM:   f.cur_lim = 1'b1; // RULE9
         RSF_FN_ZERO_CLMP: f.zero_clamp = 1'b1; // RULE9
         RSF_FN_VEL_LIM:   f.vel_lim = 1'b1; // RULE10
         RSF_FN_REF_SW:    f.ref_switch = 1'b1; // RULE11
         RSF_FN_POS_LIM:   f.positive_limit_switch = 1'b1; // RULE11
         RSF_FN_NEG_LIM:   f.negative_limit_switch = 1'b1; // RULE14
         default:          f = '0;
      endcase
      return f;
   endfunction

endpackage

`default_nettype wire

// File: rtl/rsf_input_route.sv
/*
 * Routes the synchronised digital inputs to signal input functions through
 * the active function selectors.
 * Assumes raw pins are asynchronous and the stored selectors come from the
 * parameter bank on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rsf_input_route
   import rsf_pkg::*;
#(
   parameter int N_INPUTS = rsf_pkg::RSF_N_INPUTS
)
(
   input  wire logic                      sys_clk,
   input  wire logic                      rst_b,
   input  wire logic [N_INPUTS-1:0]       din_pin,
   input  wire logic [N_INPUTS-1:0][15:0] sel_stored,
   input  wire logic                      sel_load,
   input  wire rsf_pkg::rsf_func_t        func_allow,
   output var  logic [N_INPUTS-1:0][15:0] sel_active,
   output var  rsf_pkg::rsf_func_t        func_active
);
   import rsf_pkg::*;

   logic [N_INPUTS-1:0] din_meta;
   logic [N_INPUTS-1:0] din_sync;
   rsf_func_t           per_input [N_INPUTS];
   rsf_func_t           next_func;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         din_meta <= '0;
         din_sync <= '0;
      end
      else
      begin
         din_meta <= din_pin;
         din_sync <= din_meta;
      end
   end

   // A selector only becomes active at power-on, so a running axis never
   // sees its limit switch wiring change under it.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         sel_active <= RSF_SEL_RESET; // RULE7
      else if (sel_load)
         sel_active <= sel_stored; // RULE15
   end

   ////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < N_INPUTS; i++)
   begin : g_in
      always_comb
      begin
         per_input[i] = din_sync[i] ? rsf_decode(sel_active[i]) : '0; // RULE12
      end
   end

   always_comb
   begin
      next_func = '0;
      for (int i = 0; i < N_INPUTS; i++)
         next_func = next_func | per_input[i];
      next_func = next_func & func_allow; // RULE13
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         func_active <= '0;
      else
         func_active <= next_func;
   end

endmodule

`default_nettype wire

// File: rtl/rsf_param_bank.sv
/*
 * Ramp scaling ratio and digital input function selector parameter bank.
 * Assumes a parameter access port on sys_clk from the fieldbus stack, a
 * power stage state flag and a power-on apply pulse from the same domain.
 */
// How it works
// RULE1 - Ramp ratio is velocity change in RPM/s over user acceleration units.
// RULE2 - Factory default makes one acceleration unit equal one RPM/s.
// RULE3 - Ratio terms are signed 32-bit, range 1 to 2147483647, default 1.
// RULE4 - Ramp writes accepted only while the power stage is disabled.
// RULE5 - New ratio applies on numerator write; denominator is written first.
// RULE6 - Numerator write takes effect at once, no restart needed.
// RULE7 - Defaults: input 0 free, 1 reference, 2 positive, 3 negative limit.
// RULE8 - Codes 1 free, 2 fault reset, 3 power stage enable, 4 halt.
// RULE9 - Codes 5 start positioning, 6 current limit, 7 zero clamp.
// RULE10 - Code 8 limits velocity while the input is active.
// RULE11 - Code 21 reference switch, code 22 positive limit switch.
// RULE12 - Each input has its own unsigned 16-bit function selector.
// RULE13 - Input function effect depends on operating mode and parameters.
// RULE14 - Code 23 negative limit switch.
// RULE15 - Selector changes take effect only after the next power-on.
// RULE16 - Out of range writes or writes while powered are rejected unchanged.
`timescale 1ns/1ps
`default_nettype none

module rsf_param_bank
   import rsf_pkg::*;
#(
   parameter int N_INPUTS = rsf_pkg::RSF_N_INPUTS
)
(
   input  wire logic                      sys_clk,
   input  wire logic                      rst_b,
   input  wire rsf_pkg::rsf_req_t         param_req,
   input  wire logic                      power_stage_on,
   input  wire logic                      power_on_apply,
   input  wire rsf_pkg::rsf_func_t        func_allow,
   input  wire logic [N_INPUTS-1:0]       digital_input,
   output var  logic                      param_ack,
   output var  logic                      param_nak,
   output var  logic [31:0]               param_rdata,
   output var  logic [31:0]               ramp_ratio_top,
   output var  logic [31:0]               ramp_ratio_bottom,
   output var  logic                      ramp_update,
   output var  logic [N_INPUTS-1:0][15:0] sel_active,
   output var  rsf_pkg::rsf_func_t        func_active
);
   import rsf_pkg::*;

   logic [31:0]               bottom_staged;
   logic [N_INPUTS-1:0][15:0] sel_stored;
   logic                      load_pending;
   logic                      hit_bottom;
   logic                      hit_top;
   logic [N_INPUTS-1:0]       hit_sel;
   logic                      mapped;
   logic                      ratio_ok;
   logic                      value_ok;
   logic                      wr_ok;
   logic [31:0]               next_rdata;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      hit_bottom = (param_req.addr == RSF_ADDR_BOTTOM);
      hit_top    = (param_req.addr == RSF_ADDR_TOP);
      for (int i = 0; i < N_INPUTS; i++)
         hit_sel[i] = (param_req.addr ==
                       16'(RSF_ADDR_SEL0 + 16'(i) * RSF_ADDR_SEL_STEP));
      mapped   = hit_bottom | hit_top | (|hit_sel);
      ratio_ok = (param_req.wdata >= RSF_RATIO_RESET) &&
                 (param_req.wdata <= RSF_RATIO_MAX); // RULE3
      value_ok = (hit_bottom | hit_top) ? ratio_ok
               : (param_req.wdata[31:16] == 16'h0000 &&
                  rsf_code_ok(param_req.wdata[15:0]));
      wr_ok    = param_req.wr && mapped && value_ok &&
                 !power_stage_on; // RULE4 RULE16
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (hit_bottom)
         next_rdata = bottom_staged;
      else if (hit_top)
         next_rdata = ramp_ratio_top;
      for (int i = 0; i < N_INPUTS; i++)
         if (hit_sel[i])
            next_rdata = {16'h0000, sel_stored[i]};
   end

   ////////////////////////////////////////////////////////////////////////
   // A refused access answers with a nak and leaves every value alone.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         param_ack   <= 1'b0;
         param_nak   <= 1'b0;
         param_rdata <= 32'h0000_0000;
      end
      else
      begin
         param_ack   <= (param_req.rd && mapped) || wr_ok;
         param_nak   <= (param_req.rd && !mapped) ||
                        (param_req.wr && !wr_ok); // RULE16
         param_rdata <= param_req.rd ? next_rdata : 32'h0000_0000;
      end
   end

   // The denominator waits in a staging register so that a half-written
   // ratio never reaches the ramp generator.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bottom_staged     <= RSF_RATIO_RESET; // RULE2
         ramp_ratio_top    <= RSF_RATIO_RESET; // RULE2
         ramp_ratio_bottom <= RSF_RATIO_RESET; // RULE1
         ramp_update       <= 1'b0;
      end
      else
      begin
         ramp_update <= wr_ok && hit_top; // RULE6
         if (wr_ok && hit_bottom)
            bottom_staged <= param_req.wdata;
         if (wr_ok && hit_top)
         begin
            ramp_ratio_top    <= param_req.wdata; // RULE5
            ramp_ratio_bottom <= bottom_staged; // RULE5
         end
      end
   end

   for (genvar i = 0; i < N_INPUTS; i++)
   begin : g_sel
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
         if (!rst_b)
            sel_stored[i] <= RSF_SEL_RESET[i]; // RULE7
         else if (wr_ok && hit_sel[i])
            sel_stored[i] <= param_req.wdata[15:0]; // RULE12
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         load_pending <= 1'b1;
      else
         load_pending <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   rsf_input_route #(
      .N_INPUTS (N_INPUTS)
   ) u_route (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .din_pin     (digital_input),
      .sel_stored  (sel_stored),
      .sel_load    (power_on_apply | load_pending), // RULE15
      .func_allow  (func_allow),
      .sel_active  (sel_active),
      .func_active (func_active)
   );

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   AST_BOTTOM_ONLY_ON_TOP: // RULE5
      assert property ($changed(ramp_ratio_bottom) |->
                       $past(wr_ok && hit_top))
      else $error("Ramp denominator changed without a numerator write.");

   AST_TOP_IMMEDIATE: // RULE6
      assert property ((wr_ok && hit_top) |=>
                       ramp_update && ramp_ratio_top == $past(param_req.wdata))
      else $error("Numerator write did not take effect next cycle.");

   AST_STAGED_APPLIED: // RULE1
      assert property ((wr_ok && hit_top && !param_req.addr[0]) |=>
                       ramp_ratio_bottom == $past(bottom_staged))
      else $error("Staged denominator not applied with numerator.");

   AST_RATIO_RANGE: // RULE3
      assert property (ramp_ratio_top != 32'h0 && !ramp_ratio_top[31] &&
                       ramp_ratio_bottom != 32'h0 && !ramp_ratio_bottom[31])
      else $error("Ramp ratio left its legal range.");

   AST_POWERED_REFUSED: // RULE4
      assert property ((param_req.wr && power_stage_on) |=>
                       param_nak && !param_ack && $stable(ramp_ratio_top) &&
                       $stable(bottom_staged) && $stable(sel_stored))
      else $error("Write accepted while power stage enabled.");

   AST_BAD_VALUE: // RULE16
      assert property ((param_req.wr && hit_top && !ratio_ok) |=>
                       param_nak ##0 $stable(ramp_ratio_top))
      else $error("Out of range numerator accepted.");

   AST_SEL_DEFERRED: // RULE15
      assert property ((wr_ok && (|hit_sel) && !power_on_apply) |=>
                       $stable(sel_active))
      else $error("Selector write changed active routing early.");

   AST_SEL_LOAD: // RULE15
      assert property (power_on_apply |=> sel_active == $past(sel_stored))
      else $error("Power-on did not load stored selectors.");

   AST_ONE_ANSWER: // RULE16
      assert property ((param_req.wr || param_req.rd) |=>
                       (param_ack ^ param_nak))
      else $error("Access did not get exactly one answer.");

   AST_NO_STRAY_ANSWER: // RULE16
      assert property (!(param_req.wr || param_req.rd) |=>
                       !(param_ack || param_nak))
      else $error("Answer given without a request.");

   COV_RATIO_UPDATE:
      cover property ((wr_ok && hit_bottom) ##[1:20] (wr_ok && hit_top));
   COV_POWERED_WRITE:
      cover property (param_req.wr && power_stage_on);
   COV_SEL_APPLY:
      cover property ((wr_ok && hit_sel[0]) ##[1:50] power_on_apply);

endmodule

`default_nettype wire

// File: verif/rsf_fieldbus_master.sv
/*
 * Fieldbus master model: issues single parameter reads and writes.
 * Assumes the bank takes a request on one edge and answers one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module rsf_fieldbus_master
(
   input  wire logic              sys_clk,
   input  wire logic              param_ack,
   input  wire logic              param_nak,
   input  wire logic [31:0]       param_rdata,
   output var  rsf_pkg::rsf_req_t param_req
);
   import rsf_pkg::*;

   initial param_req = '0;

   // An idle bus shows the inverse of the last value, so a bank that
   // samples address or data outside a request sees garbage.
   task automatic access(input logic wr, input logic [15:0] addr,
                         input logic [31:0] data, output logic ack,
                         output logic nak, output logic [31:0] rd);
      @(posedge sys_clk);
      #1;
      param_req = {wr, ~wr, addr, data};
      @(posedge sys_clk);
      #1;
      ack = param_ack;
      nak = param_nak;
      rd = param_rdata;
      param_req = {2'b00, ~addr, ~data};
   endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
/*
 * Self-checking bench of the ramp scaling and input function bank.
 * Assumes the fieldbus master model drives the parameter port.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
   import rsf_pkg::*;

   localparam logic [15:0] CODES [11] = '{16'h0001, 16'h0002, 16'h0003,
      16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0015,
      16'h0016, 16'h0017};
   localparam logic [15:0] BAD [4] = '{16'h0000, 16'h0009, 16'h0014,
      16'h0018};

   logic                 sys_clk = 1'b0;
   logic                 rst_b = 1'b0;
   logic                 power_stage_on = 1'b0;
   logic                 power_on_apply = 1'b0;
   rsf_func_t            func_allow = '1;
   logic [3:0]           digital_input = '0;
   rsf_req_t             param_req;
   logic                 param_ack;
   logic                 param_nak;
   logic [31:0]          param_rdata;
   logic [31:0]          ramp_ratio_top;
   logic [31:0]          ramp_ratio_bottom;
   logic                 ramp_update;
   logic [3:0][15:0]     sel_active;
   rsf_func_t            func_active;
   int                   err_count = 0;
   int                   total_checks = 0;
   int                   cycles = 0;
   int                   i;
   logic [15:0]          prev;

   always #12.5 sys_clk = ~sys_clk;

   rsf_param_bank rsf_param_bank_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .param_req(param_req), .power_stage_on(power_stage_on),
      .power_on_apply(power_on_apply), .func_allow(func_allow),
      .digital_input(digital_input), .param_ack(param_ack),
      .param_nak(param_nak), .param_rdata(param_rdata),
      .ramp_ratio_top(ramp_ratio_top), .ramp_ratio_bottom(ramp_ratio_bottom),
      .ramp_update(ramp_update), .sel_active(sel_active),
      .func_active(func_active));

   rsf_fieldbus_master rsf_fieldbus_master_inst (.sys_clk(sys_clk),
      .param_ack(param_ack), .param_nak(param_nak),
      .param_rdata(param_rdata), .param_req(param_req));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     input logic ok);
      logic k;
      logic n;
      logic [31:0] r;
      rsf_fieldbus_master_inst.access(1'b1, a, d, k, n, r);
      check("write answer", {k, n}, {ok, ~ok});
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] d,
                     input logic ok);
      logic k;
      logic n;
      logic [31:0] r;
      rsf_fieldbus_master_inst.access(1'b0, a, 32'h0, k, n, r);
      check("read answer", {k, n, r}, {ok, ~ok, d});
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // The run needs under two hundred cycles; the ceiling leaves ample margin.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      rd(16'h0660, 32'h1, 1'b1);
      rd(16'h0662, 32'h1, 1'b1);
      for (i = 0; i < 4; i++)
         rd(16'h0702 + 16'(2 * i),
            {16'h0, CODES[i == 0 ? 0 : 7 + i]}, 1'b1);
      check("sel reset", sel_active, {16'h17, 16'h16, 16'h15, 16'h1});
      rd(16'h0664, 32'h0, 1'b0);
      $display("test reset values done");

      wr(16'h0660, 32'h5, 1'b1);
      check("bottom staged", {ramp_update, ramp_ratio_bottom},
            {1'b0, 32'h1});
      rd(16'h0660, 32'h5, 1'b1);
      wr(16'h0662, 32'h7fff_ffff, 1'b1);
      check("ratio applied", {ramp_update, ramp_ratio_top},
            {1'b1, 32'h7fff_ffff});
      check("bottom applied", ramp_ratio_bottom, 32'h5);
      $display("test ratio update done");

      wr(16'h0662, 32'h0, 1'b0);
      wr(16'h0660, 32'h8000_0000, 1'b0);
      power_stage_on = 1'b1;
      wr(16'h0662, 32'h3, 1'b0);
      wr(16'h0702, 32'h2, 1'b0);
      power_stage_on = 1'b0;
      rd(16'h0660, 32'h5, 1'b1);
      check("ratio kept", {ramp_ratio_top, ramp_ratio_bottom},
            {32'h7fff_ffff, 32'h5});
      for (i = 0; i < 4; i++)
         wr(16'h0702, {16'h0, BAD[i]}, 1'b0);
      wr(16'h0702, 32'h0001_0001, 1'b0);
      $display("test refusals done");

      prev = 16'h1;
      for (i = 0; i < 11; i++)
      begin
         wr(16'h0702, {16'h0, CODES[i]}, 1'b1);
         rd(16'h0702, {16'h0, CODES[i]}, 1'b1);
         check("sel waits", sel_active[0], prev);
         power_on_apply = 1'b1;
         @(posedge sys_clk);
         #1 power_on_apply = 1'b0;
         @(posedge sys_clk);
         #1 check("sel applied", sel_active[0], CODES[i]);
         digital_input[0] = 1'b1;
         repeat (4) @(posedge sys_clk);
         #1 check("function", func_active, 11'h400 >> i);
         digital_input[0] = 1'b0;
         prev = CODES[i];
      end
      $display("test function codes done");

      wr(16'h0708, 32'h4, 1'b1);
      rd(16'h0704, 32'h15, 1'b1);
      digital_input[0] = 1'b1;
      func_allow = '0;
      repeat (4) @(posedge sys_clk);
      #1 check("masked", func_active, 11'h0);
      func_allow = '1;
      repeat (4) @(posedge sys_clk);
      #1 check("unmasked", func_active, 11'h001);
      digital_input[0] = 1'b0;
      $display("test mode mask done");
      conclude();
   end
endmodule

`default_nettype wire
